// file: dbc_counter_top.v
// dbc_counter_top.v: two banks of five counters, timebases and frequency outputs
// assumes a 100 MHz I_CLK, a plain strobed register port and asynchronous pins
module dbc_counter_top (
   input wire I_CLK,
   input wire I_RST_N,
   input wire I_CE,
   input wire [7:0] I_ADDR,
   input wire [15:0] I_WDATA,
   input wire I_WR,
   input wire I_RD,
   output reg [15:0] O_RDATA,
   input wire [7:0] I_SRC,
   input wire [9:0] I_GATE,
   output wire [9:0] O_OUT,
   output wire [9:0] O_OUT_OE,
   output wire [1:0] O_DIVIDED_FREQ_OUTPUT
);
`include "dbc_regs.vh"

   localparam integer REF_HALF = `DBC_CLK_HZ / `DBC_REF_HZ / 2 - 1;
   localparam integer FIX_HALF = `DBC_CLK_HZ / `DBC_FIX_HZ / 2 - 1;
   // half-period counts cut to the prescaler widths
   localparam [6:0] REF_LAST = REF_HALF[6:0];
   localparam [3:0] FIX_LAST = FIX_HALF[3:0];

   // pick one level out of sixteen by index
   function mux16;
      input [15:0] v;
      input [3:0] s;
      begin
         mux16 = v[s];
      end
   endfunction

   // decode a counter register hit
   function hit;
      input [7:0] a;
      input [3:0] n;
      input [1:0] sel;
      begin
         hit = (a[7:4] == n) && (a[3:2] == sel) && (a[1:0] == 2'h0);
      end
   endfunction

   reg [7:0] src_s1;
   reg [7:0] src_s2;
   reg [9:0] gate_s1;
   reg [9:0] gate_s2;
   reg [15:0] mode_q [0:9];
   reg [15:0] hold_q [0:9];
   reg [15:0] divided_freq_output_q [0:1];
   wire [159:0] cnt_w;
   wire [9:0] tc_w;
   wire [9:0] out_w;
   wire [9:0] oe_w;
   wire [9:0] run_w;
   wire [9:0] load_w;
   wire [9:0] tb_w;
   wire [1:0] fix_w;

   // two-flop synchronisers on all pins
   always @(posedge I_CLK) begin
      if (!I_RST_N) begin
         src_s1 <= 8'h00;
         src_s2 <= 8'h00;
         gate_s1 <= 10'h000;
         gate_s2 <= 10'h000;
      end else if (I_CE) begin
         src_s1 <= I_SRC;
         src_s2 <= src_s1;
         gate_s1 <= I_GATE;
         gate_s2 <= gate_s1;
      end
   end

   genvar b;
   genvar j;
   genvar n;

   // per-bank timebase chain, fixed reference and frequency output
   generate
      for (b = 0; b < 2; b = b + 1) begin : g_bank
         reg [6:0] pre_q;
         reg [4:0] tb_q;
         reg [11:0] dec_q;
         reg [3:0] fixc_q;
         reg fix_q;
         reg [3:0] fcnt_q;
         reg fprev_q;
         reg divided_freq_output_q_r;
         wire [4:0] tgl;
         wire [15:0] fsrc_v;
         wire fsrc;
         wire [3:0] fdiv = divided_freq_output_q[b][`DBC_F_FDIV];

         // 1 MHz reference from the block clock
         assign tgl[0] = (pre_q == REF_LAST);
         // each decade toggles after five rises of the faster one
         for (j = 1; j < 5; j = j + 1) begin : g_dec
            assign tgl[j] = tgl[j-1] & ~tb_q[j-1] & (dec_q[j*3-1 -: 3] == `DBC_DECADE_LAST);
         end

         always @(posedge I_CLK) begin : p_tb
            integer i;
            if (!I_RST_N) begin
               pre_q <= 7'h00;
               tb_q <= 5'h00;
               dec_q <= 12'h000;
               fixc_q <= 4'h0;
               fix_q <= 1'b0;
            end else if (I_CE) begin
               pre_q <= tgl[0] ? 7'h00 : pre_q + 7'h01;
               for (i = 0; i < 5; i = i + 1) begin
                  if (tgl[i])
                     tb_q[i] <= ~tb_q[i];
               end
               for (i = 1; i < 5; i = i + 1) begin
                  if (tgl[i-1] && !tb_q[i-1])
                     dec_q[i*3-1 -: 3] <= tgl[i] ? 3'h0 : dec_q[i*3-1 -: 3] + 3'h1;
               end
               // fixed 5 MHz reference, the fifth source of each bank
               if (fixc_q == FIX_LAST) begin
                  fixc_q <= 4'h0;
                  fix_q <= ~fix_q;
               end else begin
                  fixc_q <= fixc_q + 4'h1;
               end
            end
         end

         assign tb_w[b*5+4:b*5] = tb_q;
         assign fix_w[b] = fix_q;

         // divider source: timebase, source or gate of this bank
         assign fsrc_v = {1'b0, gate_s2[b*5+4:b*5], fix_q, src_s2[b*4+3:b*4], tb_q};
         assign fsrc = mux16(fsrc_v, divided_freq_output_q[b][`DBC_F_FSEL]);

         // divide by the 4-bit value, zero meaning sixteen
         always @(posedge I_CLK) begin
            if (!I_RST_N) begin
               fcnt_q <= 4'h0;
               fprev_q <= 1'b0;
               divided_freq_output_q_r <= 1'b0;
            end else if (I_CE) begin
               fprev_q <= fsrc;
               if (!divided_freq_output_q[b][`DBC_F_FEN]) begin
                  fcnt_q <= 4'h0;
                  divided_freq_output_q_r <= 1'b0;
               end else if (fsrc && !fprev_q) begin
                  fcnt_q <= (fcnt_q == fdiv - 4'h1) ? 4'h0 : fcnt_q + 4'h1;
                  divided_freq_output_q_r <= (fcnt_q == 4'h0);
               end
            end
         end

         assign O_DIVIDED_FREQ_OUTPUT[b] = divided_freq_output_q_r;
      end
   endgenerate

   // ten counter cells with neighbour links wrapping in each bank
   generate
      for (n = 0; n < 10; n = n + 1) begin : g_ctr
         localparam integer BK = n / 5;
         localparam integer K = n % 5;
         localparam integer LO = (K == 0) ? n + 4 : n - 1;
         localparam integer HI = (K == 4) ? n - 4 : n + 1;
         localparam integer NI = n;
         wire [15:0] sel_v;
         wire src_lvl;
         wire [15:0] hold_v;

         // bank sources: four pins, the fixed reference stands as the fifth
         // fifteen bank levels plus lower neighbour output
         assign sel_v = {out_w[LO], gate_s2[BK*5+4:BK*5],
            fix_w[BK], src_s2[BK*4+3:BK*4], tb_w[BK*5+4:BK*5]};
         assign src_lvl = mux16(sel_v, mode_q[n][`DBC_F_SRC]);
         assign load_w[n] = I_WR & hit(I_ADDR, NI[3:0], `DBC_SEL_HOLD);
         // a hold write loads a disarmed counter at once, otherwise the stored value reloads
         assign hold_v = load_w[n] ? I_WDATA : hold_q[n];

         dbc_counter u_ctr (
            .i_clk(I_CLK),
            .i_rst_n(I_RST_N),
            .i_ce(I_CE),
            .i_src(src_lvl),
            .i_gate(gate_s2[n]),
            .i_gate_up(gate_s2[HI]),
            .i_gate_dn(gate_s2[LO]),
            .i_lower_tc(tc_w[LO]),
            .i_mode(mode_q[n]),
            .i_hold(hold_v),
            .i_load(load_w[n]),
            .o_count(cnt_w[n*16+15:n*16]),
            .o_tc(tc_w[n]),
            .o_out(out_w[n]),
            .o_oe(oe_w[n]),
            .o_running(run_w[n])
         );

         // connector drive straight from the cell
         assign O_OUT[n] = out_w[n];
         assign O_OUT_OE[n] = oe_w[n];
      end
   endgenerate

   // register writes
   always @(posedge I_CLK) begin : p_wr
      integer i;
      if (!I_RST_N) begin
         for (i = 0; i < 10; i = i + 1) begin
            mode_q[i] <= `DBC_MODE_RST;
            hold_q[i] <= `DBC_HOLD_RST;
         end
         divided_freq_output_q[0] <= `DBC_DIVIDED_FREQ_OUTPUT_RST;
         divided_freq_output_q[1] <= `DBC_DIVIDED_FREQ_OUTPUT_RST;
      end else if (I_CE && I_WR) begin
         for (i = 0; i < 10; i = i + 1) begin
            if (hit(I_ADDR, i[3:0], `DBC_SEL_MODE))
               mode_q[i] <= I_WDATA;
            if (hit(I_ADDR, i[3:0], `DBC_SEL_HOLD))
               hold_q[i] <= I_WDATA;
         end
         if (I_ADDR == `DBC_OFS_DIVIDED_FREQ_OUTPUT_A)
            divided_freq_output_q[0] <= I_WDATA;
         if (I_ADDR == `DBC_OFS_DIVIDED_FREQ_OUTPUT_B)
            divided_freq_output_q[1] <= I_WDATA;
      end
   end

   // read data in the cycle after the strobe; unmapped reads zero
   always @(posedge I_CLK) begin : p_rd
      integer i;
      if (!I_RST_N) begin
         O_RDATA <= 16'h0000;
      end else if (I_CE && I_RD) begin
         O_RDATA <= 16'h0000;
         for (i = 0; i < 10; i = i + 1) begin
            if (hit(I_ADDR, i[3:0], `DBC_SEL_MODE))
               O_RDATA <= mode_q[i];
            if (hit(I_ADDR, i[3:0], `DBC_SEL_HOLD))
               O_RDATA <= hold_q[i];
            if (hit(I_ADDR, i[3:0], `DBC_SEL_COUNT))
               O_RDATA <= cnt_w[i*16 +: 16];
         end
         if (I_ADDR == `DBC_OFS_DIVIDED_FREQ_OUTPUT_A)
            O_RDATA <= divided_freq_output_q[0];
         if (I_ADDR == `DBC_OFS_DIVIDED_FREQ_OUTPUT_B)
            O_RDATA <= divided_freq_output_q[1];
         if (I_ADDR == `DBC_OFS_STATUS)
            O_RDATA <= {6'h00, run_w};
      end
   end
endmodule // dbc_counter_top

// file: dbc_regs.vh
// dbc_regs.vh: register offsets, field positions, reset values and timing counts
// assumes a 100 MHz block clock; included by the counter bank top and the counter cell
//
// Overview of operation
// - gate changes act at next counted edge
// - falling-edge gating starts on following counted edge
// - idle output is high-z, low or high
// - terminal count on rollover past 65535 or 0
// - reload count from holding register at rollover
// - pulse output high from rollover to the next counted edge
// - toggle output inverts at next edge after rollover
// - output polarity selectable, four output forms
// - starts and output changes follow counted polarity
// - bank frequency output divides by 4-bit value
// - frequency divider source is timebase, source or gate
// - two banks of five 16-bit counters each
// - bank timebases derived from 1 MHz reference
// - fifth bank source fixed at 5 MHz
// - neighbour chain wraps inside each bank
// - fifth counter has only gate and output pins
// - eight gating modes per counter
// - timebases 1 MHz down to 100 Hz
// - lower neighbour output usable as count source
`ifndef DBC_REGS_VH
`define DBC_REGS_VH

// clock and reference rates in hertz
`define DBC_CLK_HZ 100000000
`define DBC_REF_HZ 1000000
`define DBC_FIX_HZ 5000000
// decade steps between timebases, half period in edges
`define DBC_DECADE_LAST 3'h4

// register offsets (byte addresses); counter n sits at n*16
`define DBC_SEL_MODE 2'h0
`define DBC_SEL_HOLD 2'h1
`define DBC_SEL_COUNT 2'h2
`define DBC_OFS_DIVIDED_FREQ_OUTPUT_A 8'ha0
`define DBC_OFS_DIVIDED_FREQ_OUTPUT_B 8'ha4
`define DBC_OFS_STATUS 8'ha8

// counter mode fields
`define DBC_F_GATE 2:0
`define DBC_F_SRC 6:3
`define DBC_F_FALL 7
`define DBC_F_DOWN 8
`define DBC_F_RELOAD 9
`define DBC_F_TOGGLE 10
`define DBC_F_INVERT 11
`define DBC_F_IDLE 13:12
`define DBC_F_ARM 14

// idle output states
`define DBC_IDLE_HIZ 2'h0
`define DBC_IDLE_LOW 2'h1
`define DBC_IDLE_HIGH 2'h2

// gating modes
`define DBC_G_NONE 3'h0
`define DBC_G_HIGH 3'h1
`define DBC_G_LOW 3'h2
`define DBC_G_RISE 3'h3
`define DBC_G_FALL 3'h4
`define DBC_G_LOWER_TC 3'h5
`define DBC_G_UP_HIGH 3'h6
`define DBC_G_DN_HIGH 3'h7

// frequency output fields
`define DBC_F_FDIV 3:0
`define DBC_F_FSEL 7:4
`define DBC_F_FEN 8

// reset values
`define DBC_MODE_RST 16'h0000
`define DBC_HOLD_RST 16'h0000
`define DBC_DIVIDED_FREQ_OUTPUT_RST 16'h0000

`endif

// file: dbc_counter.v
// dbc_counter.v: one 16-bit counter cell with gating, reload and output shaping
// assumes source and gate levels are already synchronised to i_clk
module dbc_counter (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_ce,
   input wire i_src,
   input wire i_gate,
   input wire i_gate_up,
   input wire i_gate_dn,
   input wire i_lower_tc,
   input wire [15:0] i_mode,
   input wire [15:0] i_hold,
   input wire i_load,
   output reg [15:0] o_count,
   output reg o_tc,
   output reg o_out,
   output reg o_oe,
   output wire o_running
);
`include "dbc_regs.vh"

   reg src_q;
   reg gate_q;
   reg pend_q;
   reg start_q;
   reg ltc_q;
   reg tcc_q;
   reg tgp_q;
   reg tog_q;
   reg gate_ok;

   wire arm = i_mode[`DBC_F_ARM];
   wire [2:0] gmode = i_mode[`DBC_F_GATE];
   wire down = i_mode[`DBC_F_DOWN];
   // counted edge of the chosen polarity
   wire cnt_edge = i_mode[`DBC_F_FALL] ? (src_q & ~i_src) : (~src_q & i_src);
   wire g_rise = ~gate_q & i_gate;
   wire g_fall = gate_q & ~i_gate;
   wire wrap = down ? (o_count == 16'h0000) : (o_count == 16'hffff);

   // gate qualification for the eight modes
   always @* begin
      case (gmode)
         `DBC_G_NONE: gate_ok = 1'b1;
         `DBC_G_HIGH: gate_ok = i_gate;
         `DBC_G_LOW: gate_ok = ~i_gate;
         `DBC_G_RISE: gate_ok = start_q | pend_q;
         `DBC_G_FALL: gate_ok = start_q | pend_q;
         `DBC_G_LOWER_TC: gate_ok = ltc_q | i_lower_tc;
         `DBC_G_UP_HIGH: gate_ok = i_gate_up;
         `DBC_G_DN_HIGH: gate_ok = i_gate_dn;
         default: gate_ok = 1'b0;
      endcase
   end

   assign o_running = arm & gate_ok;

   // counting, gate capture and terminal count handling
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         src_q <= 1'b0;
         gate_q <= 1'b0;
         pend_q <= 1'b0;
         start_q <= 1'b0;
         ltc_q <= 1'b0;
         tcc_q <= 1'b0;
         tgp_q <= 1'b0;
         tog_q <= 1'b0;
         o_tc <= 1'b0;
         o_count <= `DBC_HOLD_RST;
         o_out <= 1'b0;
         o_oe <= 1'b0;
      end else if (i_ce) begin
         src_q <= i_src;
         gate_q <= i_gate;
         o_tc <= 1'b0;
         if (!arm) begin
            pend_q <= 1'b0;
            start_q <= 1'b0;
            ltc_q <= 1'b0;
            tcc_q <= 1'b0;
            tgp_q <= 1'b0;
            tog_q <= 1'b0;
            if (i_load)
               o_count <= i_hold;
            // idle drive state
            o_oe <= (i_mode[`DBC_F_IDLE] != `DBC_IDLE_HIZ);
            o_out <= (i_mode[`DBC_F_IDLE] == `DBC_IDLE_HIGH);
         end else begin
            // gate edge held in pend_q until disarm; start_q set at the next counted edge
            if ((g_rise && gmode == `DBC_G_RISE) || (g_fall && gmode == `DBC_G_FALL))
               pend_q <= 1'b1;
            if (i_lower_tc)
               ltc_q <= 1'b1;
            if (cnt_edge) begin
               if (pend_q)
                  start_q <= 1'b1;
               ltc_q <= i_lower_tc; // new pulse wins over consume
               tcc_q <= 1'b0;
               if (tgp_q) begin
                  tog_q <= ~tog_q;
                  tgp_q <= 1'b0;
               end
               if (gate_ok) begin
                  if (wrap) begin
                     o_tc <= 1'b1;
                     tcc_q <= 1'b1;
                     tgp_q <= 1'b1;
                     if (i_mode[`DBC_F_RELOAD])
                        o_count <= i_hold;
                     else
                        o_count <= down ? 16'hffff : 16'h0000;
                  end else begin
                     o_count <= down ? o_count - 16'h0001 : o_count + 16'h0001;
                  end
               end
            end
            // pulse or toggle, either polarity
            o_oe <= 1'b1;
            o_out <= (i_mode[`DBC_F_TOGGLE] ? tog_q : tcc_q) ^ i_mode[`DBC_F_INVERT];
         end
      end
   end
endmodule // dbc_counter

// file: dbc_counter_sva.sv
// dbc_counter_sva.sv: bus and output checks on the counter bank top
// assumes the strobed register port and one 100 MHz clock
module dbc_counter_sva (
   input logic I_CLK,
   input logic I_RST_N,
   input logic I_CE,
   input logic [7:0] I_ADDR,
   input logic [15:0] I_WDATA,
   input logic I_WR,
   input logic I_RD,
   input logic [15:0] O_RDATA,
   input logic [9:0] O_OUT,
   input logic [9:0] O_OUT_OE,
   input logic [1:0] O_DIVIDED_FREQ_OUTPUT
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);
   // one taken access at a byte address
   sequence s_rd(logic [7:0] a);
      I_CE && I_RD && I_ADDR == a;
   endsequence
   sequence s_wr(logic [7:0] a);
      I_CE && I_WR && I_ADDR == a;
   endsequence
   property p_unmapped_rd;
      I_CE && I_RD && (I_ADDR >= 8'hac || (I_ADDR < 8'ha0 && I_ADDR[3:0] == 4'hc)) |=> O_RDATA == 16'h0000;
   endproperty
   a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");
   property p_unaligned_rd;
      I_CE && I_RD && I_ADDR[1:0] != 2'h0 |=> O_RDATA == 16'h0000;
   endproperty
   a_unaligned_rd: assert property (p_unaligned_rd) else $error("unaligned read not zero");
   property p_status_rd;
      s_rd(8'ha8) |=> O_RDATA[15:10] == 6'h00;
   endproperty
   a_status_rd: assert property (p_status_rd) else $error("status spare bits set");
   property p_rdata_hold;
      !(I_CE && I_RD) |=> $stable(O_RDATA);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   property p_ce_freeze;
      !I_CE |=> $stable(O_OUT) && $stable(O_OUT_OE) && $stable(O_DIVIDED_FREQ_OUTPUT);
   endproperty
   a_ce_freeze: assert property (p_ce_freeze) else $error("outputs moved while frozen");
   property p_hold_readback;
      s_wr(8'h04) ##1 s_rd(8'h04) |=> O_RDATA == $past(I_WDATA, 2);
   endproperty
   a_hold_readback: assert property (p_hold_readback) else $error("hold readback wrong");
   property p_mode_readback;
      s_wr(8'h10) ##1 s_rd(8'h10) |=> O_RDATA[14:0] == $past(I_WDATA[14:0], 2);
   endproperty
   a_mode_readback: assert property (p_mode_readback) else $error("mode readback wrong");
   property p_divided_freq_output_readback;
      s_wr(8'ha0) ##1 s_rd(8'ha0) |=> O_RDATA[8:0] == $past(I_WDATA[8:0], 2);
   endproperty
   a_divided_freq_output_readback: assert property (p_divided_freq_output_readback) else $error("divider readback wrong");
   property p_idle_low;
      s_wr(8'h10) ##0 (!I_WDATA[14] && I_WDATA[13:12] == 2'h1) |-> ##[2:4] (O_OUT_OE[1] && !O_OUT[1]);
   endproperty
   a_idle_low: assert property (p_idle_low) else $error("idle low not driven");
endmodule // dbc_counter_sva

bind dbc_counter_top dbc_counter_sva u_sva (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_CE(I_CE), .I_ADDR(I_ADDR),
   .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_OUT(O_OUT), .O_OUT_OE(O_OUT_OE),
   .O_DIVIDED_FREQ_OUTPUT(O_DIVIDED_FREQ_OUTPUT));

// file: dbc_pin_model.sv
// dbc_pin_model.sv: connector side, square sources, gates and output pins
// assumes the bench clock; gates follow levels set by the bench
module dbc_pin_model #(
   parameter int HALF = 10
) (
   input wire logic clk,
   input wire logic src_en,
   input wire logic [9:0] gate_lvl,
   input wire logic [9:0] out,
   input wire logic [9:0] oe,
   output logic [7:0] src,
   output logic [9:0] gate,
   output wire [9:0] pin
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   // square waves on the source pins, low when stopped
   always @(posedge clk) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (!src_en)
         src <= 8'h00;
      else if (cnt == HALF - 1)
         src <= ~src;
      gate <= gate_lvl;
   end
   // an undriven output pin floats
   for (genvar i = 0; i < 10; i++) begin : g_pin
      assign pin[i] = oe[i] ? out[i] : 1'bz;
   end
endmodule // dbc_pin_model

// file: tb_dual_bank_gated_counter_timer.sv
// tb_dual_bank_gated_counter_timer.sv: directed tests of the counter banks
// assumes the pin model on the pins and the checker bound to the top
`include "dbc_regs.vh"
module tb_dual_bank_gated_counter_timer;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TB = `DBC_CLK_HZ / `DBC_FIX_HZ;
   logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0, src_en = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   logic [9:0] gate_lvl = 10'h3ff;
   logic [15:0] rdata;
   logic [7:0] src;
   logic [9:0] gate, out, oe;
   logic [1:0] divided_freq_output;
   wire [9:0] pin;
   int n_fail = 0, samples_checked = 0, cyc = 0;
   dbc_counter_top dut (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr),
      .I_RD(rd), .O_RDATA(rdata), .I_SRC(src), .I_GATE(gate), .O_OUT(out), .O_OUT_OE(oe), .O_DIVIDED_FREQ_OUTPUT(divided_freq_output));
   dbc_pin_model pins (.clk(clk), .src_en(src_en), .gate_lvl(gate_lvl), .out(out), .oe(oe), .src(src),
      .gate(gate), .pin(pin));
   // clock and hang guard
   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         end_of_test;
      end
   end
   task end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input logic [15:0] g, input logic [15:0] e);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // bus cycles, one strobe cycle each
   task wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rd_reg(input logic [7:0] a, output logic [15:0] v);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task rd_chk(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] v;
      rd_reg(a, v);
      chk(v, e);
   endtask
   task wr_rd(input logic [7:0] a, input logic [15:0] d, input logic [15:0] e);
      wr_reg(a, d);
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   // wait for a counter or divider output level
   task wt(input logic f, input int i, input logic lv);
      logic s;
      for (int k = 0; k < 500; k++) begin
         @(posedge clk);
         #1 s = f ? divided_freq_output[i] : out[i];
         if (s === lv)
            break;
      end
      chk({15'h0000, s}, {15'h0000, lv});
   endtask
   task t_bus;
      chk({6'h00, oe}, 16'h0000);
      chk(rdata, 16'h0000);
      wr_rd(8'h04, 16'hfffe, 16'hfffe);
      rd_chk(8'h08, 16'hfffe);
      wr_rd(8'h10, 16'h1000, 16'h1000);
      wr_rd(8'ha0, 16'h0123, 16'h0123);
      rd_chk(8'h06, 16'h0000);
      rd_chk(8'h9c, 16'h0000);
      rd_chk(8'hac, 16'h0000);
      rd_chk(8'ha8, 16'h0000);
      $display("bus test done");
   endtask
   task t_idle;
      for (int i = 0; i < 3; i++) begin
         wr_reg(8'h10, 16'(i << 12));
         repeat (3) @(posedge clk);
         #1 chk({15'h0000, pin[1]}, i == 0 ? {15'h0000, 1'bz} : 16'(i - 1));
      end
      $display("idle test done");
   endtask
   task t_pulse(input logic inv);
      int t0;
      wr_reg(8'h04, 16'hfffe);
      wr_reg(8'h00, inv ? 16'h6a48 : 16'h5248);
      wt(1'b0, 0, ~inv);
      t0 = cyc;
      rd_chk(8'h08, 16'hfffe);
      wt(1'b0, 0, inv);
      chk(16'(cyc - t0), 16'(TB));
      wr_reg(8'h00, 16'h0000);
      $display("pulse test done");
   endtask
   task t_toggle;
      int t0;
      wr_reg(8'h24, 16'hfffe);
      wr_reg(8'h20, 16'h5648); // toggled output chosen
      wt(1'b0, 2, 1'b1);
      t0 = cyc;
      wt(1'b0, 2, 1'b0);
      chk(16'(cyc - t0), 16'(2 * TB));
      wr_reg(8'h20, 16'h0000);
      $display("toggle test done");
   endtask
   task t_gate;
      logic [15:0] v;
      src_en <= 1'b1;
      wr_reg(8'h34, 16'h0000);
      wr_reg(8'h38, 16'h4040 | `DBC_G_FALL);
      wr_reg(8'h30, 16'h4040 | `DBC_G_FALL);
      repeat (100) @(posedge clk);
      rd_chk(8'h38, 16'h0000);
      gate_lvl[3] <= 1'b0;
      repeat (200) @(posedge clk);
      rd_reg(8'h38, v);
      chk(16'(v >= 9 && v <= 11), 16'h0001);
      wr_reg(8'h30, 16'h0000);
      $display("gate test done");
   endtask
   task t_modes;
      logic [15:0] v;
      for (int m = 0; m < 8; m++) begin
         wr_reg(8'h40, 16'h0000);
         wr_reg(8'h44, 16'h0000);
         wr_reg(8'h40, 16'(16'h4048 | m));
         repeat (100) @(posedge clk);
         rd_reg(8'h48, v);
         if (m != 3)
            chk(16'(v != 0), 16'(8'h43 >> m & 1));
      end
      wr_reg(8'h40, 16'h0000);
      $display("gating modes test done");
   endtask
   // down count with reload, counted by its upper neighbour on falling edges
   task t_cascade;
      int t0;
      wr_reg(8'h54, 16'h0001);
      wr_reg(8'h64, 16'h0000);
      wr_reg(8'h60, 16'h00f8);
      wr_reg(8'h60, 16'h40f8);
      wr_reg(8'h50, 16'h4348);
      wt(1'b0, 5, 1'b1);
      t0 = cyc;
      rd_chk(8'h58, 16'h0001);
      wt(1'b0, 5, 1'b0);
      chk(16'(cyc - t0), 16'(TB));
      rd_chk(8'h68, 16'h0001);
      wr_reg(8'h50, 16'h0000);
      wr_reg(8'h60, 16'h0000);
      $display("cascade test done");
   endtask
   task t_divided_freq_output(input logic [7:0] a, input logic [15:0] v, input int b, input int per);
      int t0;
      wr_reg(a, v);
      wt(1'b1, b, 1'b0);
      wt(1'b1, b, 1'b1);
      t0 = cyc;
      wt(1'b1, b, 1'b0);
      wt(1'b1, b, 1'b1);
      chk(16'(cyc - t0), 16'(per));
      ce <= 1'b0;
      repeat (4) @(posedge clk);
      ce <= 1'b1;
      wr_reg(a, 16'h0000);
      $display("divider test done");
   endtask
   // main sequence
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_bus;
      t_idle;
      t_pulse(1'b0);
      t_pulse(1'b1);
      t_toggle;
      t_gate;
      t_modes;
      t_cascade;
      t_divided_freq_output(8'ha0, 16'h0192, 0, 2 * TB);
      t_divided_freq_output(8'ha4, 16'h0103, 1, 3 * (`DBC_CLK_HZ / `DBC_REF_HZ));
      end_of_test;
   end
endmodule // tb_dual_bank_gated_counter_timer
